// ### shared/sac_pkg.sv
// Shared constants for the serial SAR conversion control block
package sac_pkg;
  // Frame edge counter width, wide enough to reach the longest frame event
  localparam int CNT_W = 6;
  // Serial clock falling edges that mark frame events (counted from 1)
  localparam logic [5:0] EDGE_SECOND_ZERO = 6'h01; // Second leading zero
  localparam logic [5:0] EDGE_FIRST_DATA = 6'h02;  // Result MSB launched
  localparam logic [5:0] EDGE_CONV_DONE = 6'h0C;   // Last bit decided
  localparam logic [5:0] EDGE_LAST_DATA = 6'h0D;   // Result LSB launched
  localparam logic [5:0] EDGE_PWRUP_CAL = 6'h10;   // Power-up calibration ends
  localparam logic [5:0] EDGE_RUN_CAL_GO = 6'h11;  // Run-time calibration starts
  localparam logic [5:0] EDGE_RUN_CAL = 6'h20;     // Run-time calibration ends
  localparam logic [5:0] EDGE_SAT = 6'h3F;         // Counter stops here
  // Reset values
  localparam logic [5:0] CNT_RESET = 6'h00;
  localparam logic CS_IDLE = 1'b1;   // Chip select idles high
  localparam logic SCLK_IDLE = 1'b0; // Serial clock assumed idle low
  // Time figures; conversion bound is 12.5 serial periods plus setup
  localparam int CLK_PERIOD_PS = 25000;      // 40 MHz system clock
  localparam int SCLK_MIN_PERIOD_PS = 62500; // Fastest serial clock
  localparam int CS_SETUP_PS = 15000;        // Select fall to first clock fall
  localparam int CONV_HALF_PERIODS = 25;     // 12.5 periods, in half periods
  localparam int CONV_MAX_PS = CONV_HALF_PERIODS * SCLK_MIN_PERIOD_PS / 2 + CS_SETUP_PS;
  localparam int CONV_MAX_CYCLES = CONV_MAX_PS / CLK_PERIOD_PS; // Longest time rounds down
  // Sequencer states, Gray along idle, convert, tail, calibrate
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_CONV = 2'b01,
    SAC_TAIL = 2'b11,
    SAC_CAL = 2'b10
  } sac_state_t;
endpackage

// ### hdl/sac_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
`default_nettype none
module sac_pin_sync #(
  parameter logic RST_VAL = 1'b1 // Level held through reset
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic pin_in, // Asynchronous pin
  output logic level, // Filtered level
  output logic fall, // One-cycle pulse on falling change
  output logic rise // One-cycle pulse on rising change
);
  logic s1_ff; // First stage, read only by second
  logic s2_ff; // Second stage
  logic s3_ff; // Third stage
  logic lvl_ff; // Accepted level
  logic nxt_lvl; // Next accepted level

  // Accept a change only when stages two and three agree
  always_comb begin
    nxt_lvl = lvl_ff;
    if (s2_ff == s3_ff) begin
      nxt_lvl = s3_ff;
    end
  end

  // Shift chain and accepted level
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      lvl_ff <= RST_VAL;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign level = lvl_ff;
  assign fall = lvl_ff & ~nxt_lvl;
  assign rise = ~lvl_ff & nxt_lvl;
endmodule
`default_nettype wire

// ### hdl/sac_core.sv
// Frame sequencer, SAR stepping, offset correction and serial output
`timescale 1ns/10ps
`default_nettype none
module sac_core #(
  parameter int RES = 12 // Result width in bits
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic rst_b, // Synchronous reset, active low, power-up
  input wire logic cs_n, // Chip select pin, active low
  input wire logic sclk, // Serial clock pin from host
  input wire logic [RES-1:0] positive_analog_input, // Positive input level in LSBs
  input wire logic [RES-1:0] negative_analog_input, // Negative input level in LSBs
  input wire logic [RES-1:0] offset_sense, // Raw code with inputs shorted
  output logic sdo_out, // Serial data output value
  output logic sdo_oe, // Data output enable, high drives
  output logic inputs_connected, // Sampling capacitors on the inputs
  output logic converting, // Conversion in progress
  output logic calibrating, // Calibration in progress
  output logic [RES-1:0] result_code, // Last corrected result
  output logic result_valid // Pulse when a result is complete
);
  import sac_pkg::*;

  logic cs_fall; // Frame start pulse
  logic cs_rise; // Frame end pulse
  logic sclk_fall; // Serial clock falling pulse

  sac_state_t state_ff; // Sequencer state
  sac_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff; // Serial falls in this frame
  logic [CNT_W-1:0] nxt_cnt;
  logic [RES-1:0] samp_ff; // Held differential sample
  logic [RES-1:0] nxt_samp;
  logic [RES-1:0] sar_ff; // Bits decided so far
  logic [RES-1:0] nxt_sar;
  logic [RES-1:0] ocs_ff; // Offset correction store
  logic [RES-1:0] nxt_ocs;
  logic pwrup_ff; // No frame seen since power-up
  logic nxt_pwrup;
  logic calfr_ff; // This frame is the power-up calibration
  logic nxt_calfr;
  logic sdo_ff;
  logic nxt_sdo;
  logic oe_ff;
  logic nxt_oe;
  logic conn_ff;
  logic nxt_conn;
  logic [RES-1:0] res_ff;
  logic [RES-1:0] nxt_res;
  logic val_ff;
  logic nxt_val;
  logic [RES-1:0] target; // Corrected value the SAR settles on
  logic [RES-1:0] trial; // Current trial code

  // Saturating unsigned subtract, floors at zero
  function automatic logic [RES-1:0] sub_sat(input logic [RES-1:0] a, input logic [RES-1:0] b);
    sub_sat = (a > b) ? (a - b) : '0;
  endfunction

  // One-hot mask of the bit decided on a given edge
  function automatic logic [RES-1:0] edge_mask(input logic [CNT_W-1:0] e);
    logic [RES-1:0] m;
    m = '0;
    for (int i = 0; i < RES; i++) begin
      if (int'(e) == RES - i) begin
        m[i] = 1'b1;
      end
    end
    edge_mask = m;
  endfunction

  sac_pin_sync #(
    .RST_VAL(CS_IDLE)
  ) u_cs_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin_in(cs_n),
    .level(),
    .fall(cs_fall),
    .rise(cs_rise)
  );

  sac_pin_sync #(
    .RST_VAL(SCLK_IDLE)
  ) u_sclk_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin_in(sclk),
    .level(),
    .fall(sclk_fall),
    .rise()
  );

  // Stored correction removed before the SAR search
  // apply stored correction
  assign target = sub_sat(samp_ff, ocs_ff);
  // Trial bit of the coming fall, taken from the register side so
  // the next-value process never feeds back on itself
  assign trial = sar_ff | edge_mask(cnt_ff + 6'h01);

  // Sequencer, SAR and output next values
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_samp = samp_ff;
    nxt_sar = sar_ff;
    nxt_ocs = ocs_ff;
    nxt_pwrup = pwrup_ff;
    nxt_calfr = calfr_ff;
    nxt_sdo = sdo_ff;
    nxt_oe = oe_ff;
    nxt_conn = conn_ff;
    nxt_res = res_ff;
    nxt_val = 1'b0;
    if (cs_fall) begin
      nxt_cnt = CNT_RESET;
      nxt_sar = '0;
      // negative difference clamps to zero code
      nxt_samp = sub_sat(positive_analog_input, negative_analog_input);
      nxt_sdo = 1'b0;
      nxt_oe = 1'b1;
      nxt_conn = 1'b0;
      nxt_pwrup = 1'b0;
      nxt_calfr = pwrup_ff;
      nxt_state = pwrup_ff ? SAC_CAL : SAC_CONV;
    end else if (cs_rise) begin
      // Frame end: release output, abandon any step in flight
      nxt_state = SAC_IDLE;
      nxt_oe = 1'b0;
      nxt_sdo = 1'b0;
      nxt_conn = 1'b1;
      nxt_calfr = 1'b0;
    end else if (sclk_fall && state_ff != SAC_IDLE) begin
      // every serial fall advances the frame until the count stops at EDGE_SAT
      nxt_cnt = (cnt_ff == EDGE_SAT) ? cnt_ff : cnt_ff + 6'h01;
      // two zeros then result, MSB first
      nxt_sdo = 1'b0;
      if (!calfr_ff && nxt_cnt >= EDGE_FIRST_DATA && nxt_cnt <= EDGE_LAST_DATA) begin
        // Bit launched was decided one fall earlier
        nxt_sdo = |(sar_ff & edge_mask(nxt_cnt - 6'h01));
      end
      case (state_ff)
        SAC_CONV: begin
          // Keep trial bit when the corrected level reaches it
          if (target >= trial) begin
            nxt_sar = trial;
          end
          // last bit decided on twelfth fall
          if (nxt_cnt == EDGE_CONV_DONE) begin
            nxt_state = SAC_TAIL;
            nxt_conn = 1'b1;
            nxt_res = (target >= trial) ? trial : sar_ff;
            nxt_val = 1'b1;
          end
        end
        SAC_TAIL: begin
          // long conversion frames go on to recalibrate
          if (!calfr_ff && nxt_cnt == EDGE_RUN_CAL_GO) begin
            nxt_state = SAC_CAL;
            nxt_conn = 1'b0;
          end
        end
        SAC_CAL: begin
          // or thirty-two in a normal frame
          if ((calfr_ff && nxt_cnt == EDGE_PWRUP_CAL) ||
              (!calfr_ff && nxt_cnt == EDGE_RUN_CAL)) begin
            nxt_ocs = offset_sense;
            nxt_conn = 1'b1;
            nxt_state = SAC_TAIL;
          end
        end
        default: begin
          nxt_state = SAC_IDLE;
        end
      endcase
    end
  end

  // Register every piece of sequencer state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_ff <= SAC_IDLE;
      cnt_ff <= CNT_RESET;
      samp_ff <= '0;
      sar_ff <= '0;
      ocs_ff <= '0;
      pwrup_ff <= 1'b1;
      calfr_ff <= 1'b0;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
      conn_ff <= 1'b1;
      res_ff <= '0;
      val_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      samp_ff <= nxt_samp;
      sar_ff <= nxt_sar;
      ocs_ff <= nxt_ocs;
      pwrup_ff <= nxt_pwrup;
      calfr_ff <= nxt_calfr;
      sdo_ff <= nxt_sdo;
      oe_ff <= nxt_oe;
      conn_ff <= nxt_conn;
      res_ff <= nxt_res;
      val_ff <= nxt_val;
    end
  end

  assign sdo_out = sdo_ff;
  assign sdo_oe = oe_ff;
  assign inputs_connected = conn_ff;
  assign converting = (state_ff == SAC_CONV);
  assign calibrating = (state_ff == SAC_CAL);
  assign result_code = res_ff;
  assign result_valid = val_ff;
endmodule
`default_nettype wire

// ### verif/sac_core_monitor.sv
// Port checker for the serial conversion control core
`timescale 1ns/10ps
`default_nettype none
module sac_core_monitor #(
  parameter int RES = 12, // Result width
  parameter int CONV_LIMIT = 108 // 12.5 serial periods plus setup, at bench rate
) (
  input wire logic clock, // System clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic cs_n, // Chip select pin
  input wire logic sclk, // Serial clock pin
  input wire logic sdo_out, // Serial data value
  input wire logic sdo_oe, // Data output enable
  input wire logic inputs_connected, // Sampling caps on inputs
  input wire logic converting, // Conversion busy
  input wire logic calibrating, // Calibration busy
  input wire logic [RES-1:0] result_code, // Last result
  input wire logic result_valid // Result pulse
);
  logic [7:0] conv_len_ff; // Cycles spent converting
  logic [7:0] nxt_conv_len; // Next count
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Count length of the running conversion
  always_comb begin
    nxt_conv_len = converting ? conv_len_ff + 8'h01 : 8'h00;
  end
  always_ff @(posedge clock) begin
    conv_len_ff <= rst_b ? nxt_conv_len : 8'h00;
  end
  chk_start_sample: assert property ($fell(cs_n) |-> ##[2:7]
    (converting || calibrating) && !inputs_connected) else $error("no start after select");
  chk_conv_bound: assert property (conv_len_ff <= CONV_LIMIT)
    else $error("conversion too long");
  chk_conv_isolated: assert property (converting |-> !inputs_connected)
    else $error("inputs connected in conversion");
  chk_done_reconnect: assert property (result_valid |-> inputs_connected && !converting)
    else $error("inputs not reconnected at result");
  chk_valid_single: assert property (result_valid |=> !result_valid)
    else $error("result pulse too long");
  chk_code_update: assert property ($changed(result_code) |-> result_valid)
    else $error("result changed without pulse");
  chk_first_zero: assert property ($fell(cs_n) |-> ##[2:7] sdo_oe && !sdo_out)
    else $error("first zero not driven");
  chk_release_out: assert property ($rose(cs_n) |-> ##[2:7] !sdo_oe)
    else $error("output not released");
  chk_cal_quiet: assert property (calibrating |-> !sdo_out && !inputs_connected)
    else $error("output high or inputs on in calibration");
  cov_result: cover property (result_valid);
  cov_cal_end: cover property (calibrating ##1 !calibrating);
  cov_abort: cover property ($rose(cs_n) && converting);
  cov_cal_clocks: cover property (calibrating && $fell(sclk));
endmodule
bind sac_core sac_core_monitor #(.RES(RES)) u_mon (.clock(clock), .rst_b(rst_b),
  .cs_n(cs_n), .sclk(sclk), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
  .inputs_connected(inputs_connected), .converting(converting),
  .calibrating(calibrating), .result_code(result_code), .result_valid(result_valid));
`default_nettype wire

// ### verif/sac_host_model.sv
// Host controller model acting as serial master
`timescale 1ns/10ps
`default_nettype none
module sac_host_model (
  output logic cs_n, // Chip select, active low
  output logic sclk, // Serial clock, idle low
  input wire logic sdo_line // Resolved data line
);
  // Select idles high, clock stands still outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
  end
  // bench runs 200 ns period; full rate would need 62.5 ns
  // frame length chosen per call; short ones are deliberate
  task automatic frame(input int falls, output logic [15:0] bits);
    bits = 16'h0000;
    cs_n = 1'b0;
    for (int i = 1; i <= falls; i++) begin
      #100 sclk = 1'b1;
      #100;
      // Sample just before the fall, a full period after launch
      if (i <= 16) begin
        bits = {bits[14:0], sdo_line};
      end
      sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    #500;
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the serial conversion control core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sac_pkg::*;
  logic clock = 1'b0; // System clock
  logic rst_b = 1'b0; // Reset, active low
  logic [11:0] pos = 12'h000; // Positive input level
  logic [11:0] neg = 12'h000; // Negative input level
  logic [11:0] offs = 12'h000; // Offset seen in calibration
  wire logic cs_n; // From host
  wire logic sclk; // From host
  logic sdo_out, sdo_oe, inputs_connected, converting, calibrating, result_valid;
  logic [11:0] result_code; // Last result
  logic last_sdo = 1'b0; // Last driven data value
  wire logic sdo_line; // Resolved data line
  int mismatches = 0;
  int check_count = 0;
  int valid_seen = 0; // Result pulses counted
  always #12.5 clock = ~clock;
  // Released line shows the inverse, so a stale value never passes
  assign sdo_line = sdo_oe ? sdo_out : ~last_sdo;
  always @(posedge clock) begin
    if (sdo_oe === 1'b1) last_sdo <= sdo_out;
    if (result_valid === 1'b1) valid_seen <= valid_seen + 1;
  end
  sac_host_model host (.cs_n(cs_n), .sclk(sclk), .sdo_line(sdo_line));
  sac_core dut (.clock(clock), .rst_b(rst_b), .cs_n(cs_n), .sclk(sclk),
    .positive_analog_input(pos), .negative_analog_input(neg), .offset_sense(offs),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .inputs_connected(inputs_connected),
    .converting(converting), .calibrating(calibrating), .result_code(result_code),
    .result_valid(result_valid));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_reset;
    @(negedge clock) rst_b = 1'b0;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
  endtask
  // One conversion frame, judged on the wire and at the result port
  task automatic conv(input logic [11:0] p, input logic [11:0] n, input int falls,
      input logic [11:0] code);
    logic [15:0] bits;
    int v0;
    @(negedge clock);
    pos = p;
    neg = n;
    v0 = valid_seen;
    host.frame(falls, bits);
    @(negedge clock);
    check("frame", bits, {2'b00, code, 2'b00});
    check("code", {4'h0, result_code}, {4'h0, code});
    check("pulses", 16'(valid_seen - v0), 16'h0001);
  endtask
  task automatic t_short_powerup;
    logic [15:0] bits;
    @(negedge clock) offs = 12'h007;
    host.frame(10, bits);
    check("pwrup_short", bits, 16'h0000);
    conv(12'h123, 12'h000, 16, 12'h123);
    $display("short power-up frame done");
  endtask
  task automatic t_powerup_cal;
    logic [15:0] bits;
    @(negedge clock) offs = 12'h005;
    host.frame(16, bits);
    check("pwrup_cal", bits, 16'h0000);
    conv(12'h100, 12'h000, 16, 12'h0FB);
    conv(12'h003, 12'h000, 16, 12'h000);
    conv(12'h010, 12'h020, 16, 12'h000);
    $display("power-up calibration done");
  endtask
  task automatic t_run_cal;
    @(negedge clock) offs = 12'h009;
    conv(12'h200, 12'h000, 31, 12'h1FB);
    conv(12'h200, 12'h000, 16, 12'h1FB);
    @(negedge clock) offs = 12'h010;
    conv(12'h800, 12'h100, 32, 12'h6FB);
    conv(12'hFFF, 12'h000, 16, 12'hFEF);
    $display("run-time calibration done");
  endtask
  task automatic t_abort;
    logic [15:0] bits;
    int v0;
    v0 = valid_seen;
    host.frame(5, bits);
    @(negedge clock);
    check("abort_pulses", 16'(valid_seen - v0), 16'h0000);
    check("abort_code", {4'h0, result_code}, 16'h0FEF);
    conv(12'h400, 12'h000, 16, 12'h3F0);
    $display("aborted frame done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    t_short_powerup();
    do_reset();
    t_powerup_cal();
    t_run_cal();
    t_abort();
    tally_and_finish();
  end
endmodule
`default_nettype wire
